// ==== hdl/pcmp_defs.vh ====
// Constants for the position compare output block: register indexes,
// attribute field positions, reset values and output pulse timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PCMP_DEFS_VH
`define PCMP_DEFS_VH

`define PCMP_CHANNELS      4
`define PCMP_IDX_W         14
`define PCMP_IDX_TGT7      14'h1912
`define PCMP_IDX_ATTR7     14'h1914
`define PCMP_IDX_TGT8      14'h1915
`define PCMP_IDX_ATTR8     14'h1917
`define PCMP_IDX_TGT9      14'h1918
`define PCMP_IDX_ATTR9     14'h191A
`define PCMP_IDX_TGT10     14'h191B
`define PCMP_IDX_ATTR10    14'h191D
`define PCMP_IDX_STATUS    14'h1930
`define PCMP_IDX_EVENT     14'h1931
`define PCMP_IDX_POS       14'h1932
`define PCMP_IDX_CAP0      14'h1934
`define PCMP_IDX_CAP1      14'h1935
`define PCMP_IDX_CAP2      14'h1936
`define PCMP_IDX_CAP3      14'h1937

`define PCMP_ATTR_W        16
`define PCMP_ATTR_RST      16'h0000
`define PCMP_TGT_RST       32'h00000000
`define PCMP_WORD_ZERO     32'h00000000
`define PCMP_B_RISE        0
`define PCMP_B_FALL        1
`define PCMP_B_DO1         7
`define PCMP_B_DO2         8
`define PCMP_B_FDA         12
`define PCMP_B_FDZ         13
`define PCMP_B_OCZ         14
`define PCMP_OUTS          5
`define PCMP_O_DO1         0
`define PCMP_O_DO2         1
`define PCMP_O_FDA         2
`define PCMP_O_FDZ         3
`define PCMP_O_OCZ         4
`define PCMP_STAT_ACT      8

`define PCMP_CLK_MHZ       50
`define PCMP_PULSE_NS      1000
`define PCMP_PULSE_CYC     ((`PCMP_PULSE_NS * `PCMP_CLK_MHZ + 999) / 1000)

`endif

// ==== hdl/pcmp_chan.v ====
// One position comparator: crossing detection and output pulse stretch.
// Assumes the sample strobe marks a fresh previous/current position pair.
`timescale 1ns/1ns
`include "pcmp_defs.vh"

module pcmp_chan #(
	parameter PULSE_CYC = `PCMP_PULSE_CYC,
	parameter CNT_W     = 16
) (
	input  wire                    sys_clk,
	input  wire                    rstn,
	input  wire                    sample_en,
	input  wire [31:0]             pos_prev,
	input  wire [31:0]             pos_cur,
	input  wire [31:0]             target,
	input  wire [`PCMP_ATTR_W-1:0] attr,
	output reg                     evt_q,
	output reg                     act_q
);

localparam integer     LAST_I = PULSE_CYC - 1;
localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

reg  [CNT_W-1:0] cnt_q;
wire             below_prev;
wire             above_cur;
wire             above_prev;
wire             below_cur;
wire             rise;
wire             fall;

////////////////////////////////////////////////////////////////////////////////
// previous against current
// The target is read live, so a new target acts on the very next sample.
assign below_prev = $signed(pos_prev) <  $signed(target);
assign above_cur  = $signed(pos_cur)  >= $signed(target);
assign above_prev = $signed(pos_prev) >  $signed(target);
assign below_cur  = $signed(pos_cur)  <= $signed(target);
assign rise = attr[`PCMP_B_RISE] & below_prev & above_cur;
assign fall = attr[`PCMP_B_FALL] & above_prev & below_cur;

////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		evt_q <= 1'b0;
		act_q <= 1'b0;
		cnt_q <= {CNT_W{1'b0}};
	end else begin
		evt_q <= sample_en & (rise | fall);
		if (sample_en & (rise | fall)) begin
			act_q <= 1'b1;
			cnt_q <= LAST;
		end else if (cnt_q != {CNT_W{1'b0}}) begin
			cnt_q <= cnt_q - 1'b1;
		end else begin
			act_q <= 1'b0;
		end
	end
end

endmodule

// ==== hdl/pcmp_top.v ====
// Position compare output block: comparator registers on Avalon-MM,
// position sampling, four comparators and the routed output pins.
// Assumes pos_valid is a one-cycle strobe synchronous to sys_clk and
// a bus master that holds each request until waitrequest is seen low.
`timescale 1ns/1ns
`include "pcmp_defs.vh"

module pcmp_top #(
	parameter N         = `PCMP_CHANNELS,
	parameter PULSE_CYC = `PCMP_PULSE_CYC
) (
	input  wire        sys_clk,
	input  wire        rstn,
	input  wire [15:0] avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        pos_valid,
	input  wire [31:0] pos_value,
	output wire        general_output_one,
	output wire        general_output_two,
	output wire        freq_div_a_out,
	output wire        freq_div_index_out,
	output wire        open_collector_index_out
);

////////////////////////////////////////////////////////////////////////////////
// Register index of each comparator's words.

function [`PCMP_IDX_W-1:0] idx_tgt;
	input integer ch;
	begin
		case (ch)
			0:       idx_tgt = `PCMP_IDX_TGT7;
			1:       idx_tgt = `PCMP_IDX_TGT8;
			2:       idx_tgt = `PCMP_IDX_TGT9;
			default: idx_tgt = `PCMP_IDX_TGT10;
		endcase
	end
endfunction

function [`PCMP_IDX_W-1:0] idx_attr;
	input integer ch;
	begin
		case (ch)
			0:       idx_attr = `PCMP_IDX_ATTR7;
			1:       idx_attr = `PCMP_IDX_ATTR8;
			2:       idx_attr = `PCMP_IDX_ATTR9;
			default: idx_attr = `PCMP_IDX_ATTR10;
		endcase
	end
endfunction

function [`PCMP_IDX_W-1:0] idx_cap;
	input integer ch;
	begin
		case (ch)
			0:       idx_cap = `PCMP_IDX_CAP0;
			1:       idx_cap = `PCMP_IDX_CAP1;
			2:       idx_cap = `PCMP_IDX_CAP2;
			default: idx_cap = `PCMP_IDX_CAP3;
		endcase
	end
endfunction

// Byte-lane merge of a write into a stored word.
function [31:0] merge_be;
	input [31:0] old;
	input [31:0] wd;
	input [3:0]  be;
	integer      b;
	begin
		merge_be = old;
		for (b = 0; b < 4; b = b + 1) begin
			if (be[b]) begin
				merge_be[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave handshake.

// Bus handshake states, one-hot.
localparam [1:0] BUS_IDLE   = 2'b01;
localparam [1:0] BUS_ANSWER = 2'b10;

reg  [1:0]            bus_q;
reg  [1:0]            bus_d;
wire                  stall;
reg  [31:0]           rdata_q;
reg  [31:0]           rdata_d;
wire [`PCMP_IDX_W-1:0] idx;
wire                  req;
wire                  wr_fire;
wire                  aligned;

assign idx     = avs_address[15:2];
assign aligned = (avs_address[1:0] == 2'h0);
assign req     = avs_read | avs_write;
// The idle bit of the one-hot code is the stall itself.
assign stall   = bus_q[0];
// Writes land only at the edge where the master sees waitrequest low.
assign wr_fire = avs_write & ~stall & aligned;

assign avs_waitrequest = bus_q[0];
assign avs_readdata    = rdata_q;

// Every access takes exactly one wait cycle; readdata is settled by then.
always @* begin
	bus_d = bus_q;
	case (bus_q)
		BUS_IDLE: begin
			if (req) begin
				bus_d = BUS_ANSWER;
			end
		end
		BUS_ANSWER: begin
			bus_d = BUS_IDLE;
		end
		// An illegal code falls back to idle so a glitch cannot hang the bus.
		default: begin
			bus_d = BUS_IDLE;
		end
	endcase
end

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		bus_q <= BUS_IDLE;
	end else begin
		bus_q <= bus_d;
	end
end

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		rdata_q <= `PCMP_WORD_ZERO;
	end else if (avs_read & stall) begin
		rdata_q <= rdata_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Position sampling.

reg  [31:0] pos_cur_q;
reg  [31:0] pos_prev_q;
reg  [1:0]  seen_q;
reg         sample_q;

// A crossing needs two real samples, so the first update never fires.
always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		pos_cur_q  <= `PCMP_WORD_ZERO;
		pos_prev_q <= `PCMP_WORD_ZERO;
		seen_q     <= 2'h0;
		sample_q   <= 1'b0;
	end else begin
		sample_q <= pos_valid & seen_q[0];
		if (pos_valid) begin
			pos_prev_q <= pos_cur_q;
			pos_cur_q  <= pos_value;
			seen_q     <= {seen_q[0], 1'b1};
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Comparator registers and comparators.

wire [32*N-1:0]              tgt_flat;
wire [`PCMP_ATTR_W*N-1:0]    attr_flat;
wire [32*N-1:0]              cap_flat;
wire [N-1:0]                 evt;
wire [N-1:0]                 act;
wire [`PCMP_OUTS*N-1:0]      route_flat;

genvar g;
generate
	for (g = 0; g < N; g = g + 1) begin : g_ch
		reg  [31:0]              tgt_q;
		reg  [`PCMP_ATTR_W-1:0]  attr_q;
		reg  [31:0]              cap_q;
		wire                     tsel;
		wire                     asel;
		wire [31:0]              attr_wide;

		assign tsel      = wr_fire & (idx == idx_tgt(g));
		assign asel      = wr_fire & (idx == idx_attr(g));
		assign attr_wide = merge_be({16'h0000, attr_q}, avs_writedata, avs_byteenable);

		always @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				tgt_q <= `PCMP_TGT_RST;
			end else if (tsel) begin
				tgt_q <= merge_be(tgt_q, avs_writedata, avs_byteenable);
			end
		end

		always @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				attr_q <= `PCMP_ATTR_RST;
			end else if (asel) begin
				attr_q <= attr_wide[`PCMP_ATTR_W-1:0];
			end
		end

		// Position at the last crossing, for software to inspect.
		always @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				cap_q <= `PCMP_WORD_ZERO;
			end else if (evt[g]) begin
				cap_q <= pos_cur_q;
			end
		end

		assign tgt_flat[g*32 +: 32]                    = tgt_q;
		assign attr_flat[g*`PCMP_ATTR_W +: `PCMP_ATTR_W] = attr_q;
		assign cap_flat[g*32 +: 32]                    = cap_q;

		pcmp_chan #(
			.PULSE_CYC (PULSE_CYC)
		) u_chan (
			.sys_clk   (sys_clk),
			.rstn      (rstn),
			.sample_en (sample_q),
			.pos_prev  (pos_prev_q),
			.pos_cur   (pos_cur_q),
			.target    (tgt_q),
			.attr      (attr_q),
			.evt_q     (evt[g]),
			.act_q     (act[g])
		);

		assign route_flat[g*`PCMP_OUTS + `PCMP_O_DO1] = act[g] & attr_q[`PCMP_B_DO1];
		assign route_flat[g*`PCMP_OUTS + `PCMP_O_DO2] = act[g] & attr_q[`PCMP_B_DO2];
		assign route_flat[g*`PCMP_OUTS + `PCMP_O_FDA] = act[g] & attr_q[`PCMP_B_FDA];
		assign route_flat[g*`PCMP_OUTS + `PCMP_O_FDZ] = act[g] & attr_q[`PCMP_B_FDZ];
		assign route_flat[g*`PCMP_OUTS + `PCMP_O_OCZ] = act[g] & attr_q[`PCMP_B_OCZ];
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Output pins: OR of every comparator that routes to a pin.

reg  [`PCMP_OUTS-1:0] out_d;
reg  [`PCMP_OUTS-1:0] out_q;
integer               k;

// Routing is combinational on the attribute, so clearing a route bit
// drops the pin on the next edge even mid-pulse.
always @* begin
	out_d = {`PCMP_OUTS{1'b0}};
	for (k = 0; k < N; k = k + 1) begin
		out_d = out_d | route_flat[k*`PCMP_OUTS +: `PCMP_OUTS];
	end
end

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		out_q <= {`PCMP_OUTS{1'b0}};
	end else begin
		out_q <= out_d;
	end
end

assign general_output_one       = out_q[`PCMP_O_DO1];
assign general_output_two       = out_q[`PCMP_O_DO2];
assign freq_div_a_out           = out_q[`PCMP_O_FDA];
assign freq_div_index_out       = out_q[`PCMP_O_FDZ];
assign open_collector_index_out = out_q[`PCMP_O_OCZ];

////////////////////////////////////////////////////////////////////////////////
// Sticky crossing flags, cleared by writing one.

reg  [N-1:0] ev_q;
wire         ev_clr;

assign ev_clr = wr_fire & (idx == `PCMP_IDX_EVENT) & avs_byteenable[0];

// A crossing in the clearing cycle survives: the set is applied last.
always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		ev_q <= {N{1'b0}};
	end else begin
		ev_q <= (ev_q & ~(ev_clr ? avs_writedata[N-1:0] : {N{1'b0}})) | evt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read multiplexer; unmapped indexes read zero.

integer r;

always @* begin
	rdata_d = `PCMP_WORD_ZERO;
	if (aligned) begin
		for (r = 0; r < N; r = r + 1) begin
			if (idx == idx_tgt(r)) begin
				rdata_d = tgt_flat[r*32 +: 32];
			end
			if (idx == idx_attr(r)) begin
				rdata_d[`PCMP_ATTR_W-1:0] = attr_flat[r*`PCMP_ATTR_W +: `PCMP_ATTR_W];
			end
			if (idx == idx_cap(r)) begin
				rdata_d = cap_flat[r*32 +: 32];
			end
		end
		if (idx == `PCMP_IDX_STATUS) begin
			rdata_d[`PCMP_OUTS-1:0]   = out_q;
			rdata_d[`PCMP_STAT_ACT +: N] = act;
		end
		if (idx == `PCMP_IDX_EVENT) begin
			rdata_d[N-1:0] = ev_q;
		end
		if (idx == `PCMP_IDX_POS) begin
			rdata_d = pos_cur_q;
		end
	end
end

endmodule

// ==== test/pcmp_props.sv ====
// Checker for pcmp_top: bus answer timing and the causes of pin pulses.
// Assumes it is bound to pcmp_top and sees only its ports.
`timescale 1ns/1ns
module pcmp_props (
	input wire sys_clk,
	input wire rstn,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire pos_valid,
	input wire general_output_one,
	input wire general_output_two,
	input wire freq_div_a_out,
	input wire freq_div_index_out,
	input wire open_collector_index_out
);
	reg  [2:0] v_q;
	reg  [1:0] w_q;
	wire       cause;
	// A pin may also rise when a route bit is set mid-pulse, so writes count as a cause.
	assign cause = v_q[1] | v_q[2] | w_q[0] | w_q[1];
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			v_q <= 3'h0;
			w_q <= 2'h0;
		end else begin
			v_q <= {v_q[1:0], pos_valid};
			w_q <= {w_q[0], avs_write};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Bus request not answered after one wait cycle.");
	AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("Wait release lasted more than one cycle.");
	AST_BUS_IDLE: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("Wait released without a request.");
	AST_DO1_CAUSE: assert property ($rose(general_output_one) |-> cause)
		else $error("First general output rose without cause.");
	AST_DO2_CAUSE: assert property ($rose(general_output_two) |-> cause)
		else $error("Second general output rose without cause.");
	AST_FDA_CAUSE: assert property ($rose(freq_div_a_out) |-> cause)
		else $error("A-phase output rose without cause.");
	AST_FDZ_CAUSE: assert property ($rose(freq_div_index_out) |-> cause)
		else $error("Index output rose without cause.");
	AST_OCZ_CAUSE: assert property ($rose(open_collector_index_out) |-> cause)
		else $error("Open-collector index rose without cause.");
endmodule
bind pcmp_top pcmp_props u_pcmp_props (.sys_clk(sys_clk), .rstn(rstn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pos_valid(pos_valid),
	.general_output_one(general_output_one), .general_output_two(general_output_two),
	.freq_div_a_out(freq_div_a_out), .freq_div_index_out(freq_div_index_out),
	.open_collector_index_out(open_collector_index_out));

// ==== test/pcmp_host.sv ====
// Host model: Avalon-MM master for the compare registers and position source.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module pcmp_host (
	input  wire        sys_clk,
	output reg  [15:0] avs_address,
	output reg         avs_read,
	output reg         avs_write,
	output reg  [31:0] avs_writedata,
	output reg  [3:0]  avs_byteenable,
	input  wire [31:0] avs_readdata,
	input  wire        avs_waitrequest,
	output reg         pos_valid,
	output reg  [31:0] pos_value
);
	initial begin
		avs_address = 16'h0000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		pos_valid = 1'b0;
		pos_value = 32'h00000000;
	end
	////////////////////////////////////////////////////////////////////////////
	task xfer(input rw, input [13:0] idx, input [31:0] wd, output [31:0] rd);
		begin
			@(posedge sys_clk);
			avs_address <= {idx, 2'b00};
			avs_read <= !rw;
			avs_write <= rw;
			avs_writedata <= wd;
			avs_byteenable <= 4'hF;
			@(posedge sys_clk);
			while (avs_waitrequest)
				@(posedge sys_clk);
			rd = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			// Stale data is inverted so nothing can lean on it.
			avs_writedata <= ~wd;
		end
	endtask
	task sample(input [31:0] v);
		begin
			@(posedge sys_clk);
			pos_valid <= 1'b1;
			pos_value <= v;
			@(posedge sys_clk);
			pos_valid <= 1'b0;
			pos_value <= ~v;
		end
	endtask
endmodule

// ==== test/pcmp_top_test.sv ====
// Self-checking bench for pcmp_top: register table, crossings and routing.
// Assumes the host model drives every bus and position input.
`timescale 1ns/1ns
`include "pcmp_defs.vh"
module pcmp_top_test;
	reg         sys_clk;
	reg         rstn;
	wire [15:0] a_adr;
	wire        a_rd;
	wire        a_wr;
	wire [31:0] a_wd;
	wire [3:0]  a_be;
	wire [31:0] a_rdat;
	wire        a_wait;
	wire        p_vld;
	wire [31:0] p_val;
	wire [4:0]  pins;
	integer     n_fail;
	integer     cmp_count;
	integer     cyc = 0;
	integer     i;
	reg  [31:0] rd;
	reg  [31:0] w;
	reg  [31:0] t;
	reg  [4:0]  seen;
	pcmp_top #(.PULSE_CYC(3)) u_pcmp_top (.sys_clk(sys_clk), .rstn(rstn), .avs_address(a_adr),
		.avs_read(a_rd), .avs_write(a_wr), .avs_writedata(a_wd), .avs_byteenable(a_be),
		.avs_readdata(a_rdat), .avs_waitrequest(a_wait), .pos_valid(p_vld), .pos_value(p_val),
		.general_output_one(pins[0]), .general_output_two(pins[1]), .freq_div_a_out(pins[2]),
		.freq_div_index_out(pins[3]), .open_collector_index_out(pins[4]));
	pcmp_host u_pcmp_host (.sys_clk(sys_clk), .avs_address(a_adr), .avs_read(a_rd),
		.avs_write(a_wr), .avs_writedata(a_wd), .avs_byteenable(a_be), .avs_readdata(a_rdat),
		.avs_waitrequest(a_wait), .pos_valid(p_vld), .pos_value(p_val));
	////////////////////////////////////////////////////////////////////////////
	function [13:0] ridx(input integer k);
		case (k)
			0: ridx = `PCMP_IDX_TGT7;
			1: ridx = `PCMP_IDX_ATTR7;
			2: ridx = `PCMP_IDX_TGT8;
			3: ridx = `PCMP_IDX_ATTR8;
			4: ridx = `PCMP_IDX_TGT9;
			5: ridx = `PCMP_IDX_ATTR9;
			6: ridx = `PCMP_IDX_TGT10;
			default: ridx = `PCMP_IDX_ATTR10;
		endcase
	endfunction
	function exp_hit(input [15:0] a, input [31:0] t, input [31:0] p, input [31:0] c);
		exp_hit = (a[0] && $signed(p) < $signed(t) && $signed(c) >= $signed(t))
			|| (a[1] && $signed(p) > $signed(t) && $signed(c) <= $signed(t));
	endfunction
	function [4:0] exp_pins(input [15:0] a, input [31:0] t, input [31:0] p, input [31:0] c);
		exp_pins = exp_hit(a, t, p, c) ? {a[14], a[13], a[12], a[8], a[7]} : 5'h00;
	endfunction
	task check(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Previous sample is sent with the attribute cleared, so only the pair counts.
	task trial(input [1:0] ch, input [15:0] a, input [31:0] t, input [31:0] p, input [31:0] c);
		begin
			u_pcmp_host.xfer(1'b1, ridx(2 * ch + 1), 32'h0, rd);
			u_pcmp_host.sample(p);
			u_pcmp_host.xfer(1'b1, ridx(2 * ch), t, rd);
			u_pcmp_host.xfer(1'b1, ridx(2 * ch + 1), {16'h0, a}, rd);
			u_pcmp_host.sample(c);
			seen = 5'h00;
			repeat (10) begin
				@(posedge sys_clk);
				seen = seen | pins;
			end
			check({27'h0, seen}, {27'h0, exp_pins(a, t, p, c)});
			u_pcmp_host.xfer(1'b0, `PCMP_IDX_EVENT, 32'h0, rd);
			check(rd, {28'h0, (exp_hit(a, t, p, c) ? (4'h1 << ch) : 4'h0)});
			if (exp_hit(a, t, p, c)) begin
				u_pcmp_host.xfer(1'b0, `PCMP_IDX_CAP0 + ch, 32'h0, rd);
				check(rd, c);
			end
			u_pcmp_host.xfer(1'b1, `PCMP_IDX_EVENT, 32'hF, rd);
			u_pcmp_host.xfer(1'b1, ridx(2 * ch + 1), 32'h0, rd);
		end
	endtask
	task close_out;
		begin
			$display("Checks %0d, mismatches %0d", cmp_count, n_fail);
			if (n_fail == 0 && cmp_count > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			close_out;
		end
	end
	initial begin
		n_fail = 0;
		cmp_count = 0;
		rstn = 1'b0;
		i = $urandom(48717);
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			u_pcmp_host.xfer(1'b0, ridx(i), 32'h0, rd);
			check(rd, 32'h0);
			w = (i == 2) ? 32'h80000000 : (i == 4) ? 32'h7FFFFFFF : $urandom;
			u_pcmp_host.xfer(1'b1, ridx(i), w, rd);
			u_pcmp_host.xfer(1'b0, ridx(i), 32'h0, rd);
			check(rd, i[0] ? {16'h0, w[15:0]} : w);
			u_pcmp_host.xfer(1'b1, ridx(i), 32'h0, rd);
		end
		u_pcmp_host.xfer(1'b1, 14'h1913, 32'hFFFFFFFF, rd);
		u_pcmp_host.xfer(1'b0, 14'h1913, 32'h0, rd);
		check(rd, 32'h0);
		for (i = 0; i < 8; i = i + 1) begin
			u_pcmp_host.xfer(1'b1, ridx(i), $urandom | 32'h1, rd);
		end
		rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			u_pcmp_host.xfer(1'b0, ridx(i), 32'h0, rd);
			check(rd, 32'h0);
		end
		for (i = 0; i < 5; i = i + 1) begin
			w = (i < 2) ? (32'h80 << i) : (32'h1000 << (i - 2));
			trial(i[1:0], w[15:0] | 16'h0001, 32'h7FFFFFFF, 32'h7FFFFFFE, 32'h7FFFFFFF);
			trial(i[1:0], w[15:0] | 16'h0002, 32'h80000000, 32'h80000001, 32'h80000000);
			trial(i[1:0], w[15:0] | 16'h0002, 32'h00000005, 32'h00000004, 32'h00000006);
		end
		for (i = 0; i < 40; i = i + 1) begin
			w = $urandom;
			t = $urandom;
			trial(w[1:0], w[17:2], t, t + ($urandom % 5) - 2, t + ($urandom % 5) - 2);
		end
		close_out;
	end
endmodule
